// ==== hw/sps_regs.vh ====
/*
 * Register indices, field positions, reset values and timing counts of the
 * stepper phase sequencer.
 * Assumes a 25 MHz system clock and word-per-register AXI4-Lite access.
 */
`ifndef SPS_REGS_VH
`define SPS_REGS_VH

// Register indices; byte address is four times the index
`define SPS_IDX_INTERVAL_MODE_CTRL 16'hFFB0
`define SPS_IDX_INTERVAL_COUNT 16'hFFB1
`define SPS_IDX_STEP_COMPARE_VALUE 16'hFFBA
`define SPS_IDX_PHASE_OUT_DATA 16'hFFD9
`define SPS_IDX_IRQ_REQUEST_FLAGS_ONE 16'hFFF6
`define SPS_IDX_MOTOR_CTRL 16'hFFC0
`define SPS_IDX_IRQ_STATUS 16'hFFC1
`define SPS_IDX_IRQ_MASK 16'hFFC2
`define SPS_IDX_STEP_TIMER_COUNT 16'hFFC3
`define SPS_IDX_INDEX_STATUS 16'hFFC4

// Field positions
`define SPS_INTERVAL_IRQ_FLAG_BIT 3
`define SPS_CTRL_CLEAR_EN_BIT 3
`define SPS_IRQ_STEP_BIT 0
`define SPS_IRQ_INTERVAL_BIT 1
`define SPS_IRQ_RAMP_BIT 2

// Interval clock select codes
`define SPS_CSEL_INTERVAL 4'h6
`define SPS_CSEL_RESET_MIN 4'hC

// Operating modes, bit 2 selects reverse rotation
`define SPS_MODE_SLEW_UP 2'h0
`define SPS_MODE_CONST 2'h1
`define SPS_MODE_SLEW_DOWN 2'h2
`define SPS_MODE_STOP 2'h3

// Reset values
`define SPS_RST_COMPARE 16'h2710
`define SPS_RST_PHASE_OUT 8'h08
`define SPS_RST_PINS 4'h8
`define SPS_RST_MODE 3'h3
`define SPS_RST_INTERVAL_MODE 8'h00

// Ramp table: linear, first entry and spacing between entries
`define SPS_RAMP_BASE 16'h2710
`define SPS_RAMP_DELTA 16'h00AF
`define SPS_RAMP_LAST 6'h2F

// Prescaler divisions
`define SPS_STEP_DIV 5'h0F
`define SPS_INTERVAL_DIV 5'h1F

`endif

// ==== hw/sps_stepper_phase_sequencer.v ====
/*
 * Stepper phase sequencer: step compare timer with ramp reload, half-step
 * pattern sequencing with an interval-timed non-overlap gap, AXI4-Lite slave.
 * Assumes one 25 MHz clock, synchronous reset and phase drivers on the four
 * phase outputs; AXI master keeps one write and one read in flight at most.
 */
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "sps_regs.vh"

// Behaviour
// - Step event whenever the 16-bit step timer count equals the compare value.
// - Forward slew-down: each step loads compare from ramp table, then moves the index.
// - Ramp table holds 48 sixteen-bit step intervals for both slews.
// - Reverse slew-up: load compare from ramp, increment index, then constant speed.
// - Reverse slew-down: load compare from ramp at index, then update index.
// - Four phase outputs carry the pattern table entry at the phase index.
// - Forward constant: each step outputs next pattern, compare value unchanged.
// - Reverse constant: each step outputs pattern at phase index, reverse direction.
// - A non-overlap gap timed by the interval timer precedes each new pattern.
// - Interval flag bit 3 shows pending request; cleared when a gap is armed.
// - Writing clock select C to F resets the interval counter.
// - Clock select 6 runs the interval timer from prescaler S.
// - Interval counter is an 8-bit up-counter at system clock divided by 32.
// - Pattern table: 08 0C 04 06 02 03 01 09, bit 3 phase A.
// - Step timer clears on compare match when compare clearing is enabled.
// - 3-bit mode: 0-3 forward slew-up/constant/slew-down/stop, 4-7 reverse.
module sps_stepper_phase_sequencer (
    input wire mclk,
    input wire srst,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [3:0] phase_output_bits,
    output reg irq
);

    // Half-step excitation codes
    function [3:0] pattern;
        input [2:0] idx;
        begin
            case (idx)
                3'h0: pattern = 4'h8;
                3'h1: pattern = 4'hC;
                3'h2: pattern = 4'h4;
                3'h3: pattern = 4'h6;
                3'h4: pattern = 4'h2;
                3'h5: pattern = 4'h3;
                3'h6: pattern = 4'h1;
                default: pattern = 4'h9;
            endcase
        end
    endfunction

    // Table entries fall linearly, so a multiply replaces 48 stored words
    function [15:0] ramp_period;
        input [5:0] idx;
        reg [15:0] prod;
        begin
            prod = {10'h000, idx} * `SPS_RAMP_DELTA;
            ramp_period = `SPS_RAMP_BASE - prod;
        end
    endfunction

    // Register index from a byte address
    function [15:0] reg_index;
        input [31:0] addr;
        begin
            reg_index = addr[17:2];
        end
    endfunction

    function mapped;
        input [15:0] idx;
        begin
            case (idx)
                `SPS_IDX_INTERVAL_MODE_CTRL, `SPS_IDX_INTERVAL_COUNT,
                `SPS_IDX_STEP_COMPARE_VALUE, `SPS_IDX_PHASE_OUT_DATA,
                `SPS_IDX_IRQ_REQUEST_FLAGS_ONE, `SPS_IDX_MOTOR_CTRL,
                `SPS_IDX_IRQ_STATUS, `SPS_IDX_IRQ_MASK,
                `SPS_IDX_STEP_TIMER_COUNT, `SPS_IDX_INDEX_STATUS: mapped = 1'b1;
                default: mapped = 1'b0;
            endcase
        end
    endfunction

    reg [7:0] interval_mode_ctrl;
    reg [7:0] interval_count;
    reg [15:0] step_compare_value;
    reg [15:0] step_timer_count;
    reg [7:0] phase_out_data;
    reg interval_irq_flag;
    reg [2:0] mode;
    reg compare_clear_enable;
    reg [2:0] irq_status;
    reg [2:0] irq_mask;
    reg [2:0] phase_idx;
    reg [5:0] ramp_idx;
    reg gap_busy;
    reg [4:0] step_div;
    reg [4:0] prescaler_s;
    reg step_tick;
    reg interval_tick;
    reg step_event;
    reg [15:0] aw_idx;
    reg aw_held;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg w_held;

    wire [3:0] interval_clock_select = interval_mode_ctrl[3:0];
    wire do_write = aw_held && w_held && !s_axi_bvalid;
    wire wr_low = do_write && w_strb[0];
    wire interval_ovf = interval_tick && (interval_count == 8'hFF);
    wire moving = (mode[1:0] != `SPS_MODE_STOP);
    wire reverse = mode[2];
    wire ramp_wrap = step_event && moving && !mode[0] &&
        ((mode[1] == 1'b0 && ramp_idx == `SPS_RAMP_LAST) ||
         (mode[1] == 1'b1 && ramp_idx == 6'h00));
    wire [2:0] irq_events = {ramp_wrap, interval_ovf, step_event};

    // Prescalers: one-cycle enables, step timer at /16, interval timer at /32
    always @(posedge mclk) begin
        if (srst) begin
            step_div <= 5'h00;
            prescaler_s <= 5'h00;
            step_tick <= 1'b0;
            interval_tick <= 1'b0;
        end else begin
            step_div <= (step_div == `SPS_STEP_DIV) ? 5'h00 : step_div + 5'h01;
            prescaler_s <= prescaler_s + 5'h01;
            step_tick <= (step_div == `SPS_STEP_DIV);
            // Runs only with the interval select code
            interval_tick <= (prescaler_s == `SPS_INTERVAL_DIV) &&
                (interval_clock_select == `SPS_CSEL_INTERVAL);
        end
    end

    // Step timer; the match is taken on a tick so the event is one cycle long
    always @(posedge mclk) begin
        if (srst) begin
            step_timer_count <= 16'h0000;
            step_event <= 1'b0;
        end else begin
            step_event <= 1'b0;
            if (step_tick) begin
                if (step_timer_count == step_compare_value) begin
                    step_event <= 1'b1;
                    if (compare_clear_enable) begin
                        step_timer_count <= 16'h0000;
                    end else begin
                        step_timer_count <= step_timer_count + 16'h0001;
                    end
                end else begin
                    step_timer_count <= step_timer_count + 16'h0001;
                end
            end
        end
    end

    // Interval counter and its request flag; the overflow set beats a clear
    always @(posedge mclk) begin
        if (srst) begin
            interval_count <= 8'h00;
            interval_irq_flag <= 1'b0;
        end else begin
            if (do_write && aw_idx == `SPS_IDX_INTERVAL_MODE_CTRL && w_strb[0] &&
                    w_data[3:0] >= `SPS_CSEL_RESET_MIN) begin
                interval_count <= 8'h00;
            end else if (step_event && moving) begin
                interval_count <= 8'h00;
            end else if (interval_tick && interval_clock_select == `SPS_CSEL_INTERVAL) begin
                interval_count <= interval_count + 8'h01;
            end
            if (interval_ovf) begin
                interval_irq_flag <= 1'b1;
            end else if (step_event && moving) begin
                interval_irq_flag <= 1'b0;
            end else if (wr_low && aw_idx == `SPS_IDX_IRQ_REQUEST_FLAGS_ONE &&
                    !w_data[`SPS_INTERVAL_IRQ_FLAG_BIT]) begin
                interval_irq_flag <= 1'b0;
            end
        end
    end

    // Sequencer: mode, ramp reload, phase index and the non-overlap gap.
    // A software write to the mode wins over a hardware mode change.
    always @(posedge mclk) begin
        if (srst) begin
            mode <= `SPS_RST_MODE;
            compare_clear_enable <= 1'b1;
            step_compare_value <= `SPS_RST_COMPARE;
            ramp_idx <= 6'h00;
            phase_idx <= 3'h0;
            phase_out_data <= `SPS_RST_PHASE_OUT;
            gap_busy <= 1'b0;
        end else begin
            if (step_event && moving) begin
                // Index wraps through the 3-bit width
                phase_idx <= reverse ? phase_idx - 3'h1 : phase_idx + 3'h1;
                phase_out_data <= 8'h00;
                gap_busy <= 1'b1;
                case (mode[1:0])
                    `SPS_MODE_SLEW_UP: begin
                        step_compare_value <= ramp_period(ramp_idx);
                        if (ramp_idx == `SPS_RAMP_LAST) begin
                            mode <= {reverse, `SPS_MODE_CONST};
                        end else begin
                            ramp_idx <= ramp_idx + 6'h01;
                        end
                    end
                    `SPS_MODE_SLEW_DOWN: begin
                        step_compare_value <= ramp_period(ramp_idx);
                        if (ramp_idx == 6'h00) begin
                            mode <= {reverse, `SPS_MODE_STOP};
                        end else begin
                            ramp_idx <= ramp_idx - 6'h01;
                        end
                    end
                    default: begin
                        // Constant speed keeps the compare value
                        step_compare_value <= step_compare_value;
                    end
                endcase
            end else if (gap_busy && interval_irq_flag) begin
                phase_out_data <= {4'h0, pattern(phase_idx)};
                gap_busy <= 1'b0;
            end
            // Stop modes leave the index alone; a gap still pending loads its pattern
            if (do_write) begin
                case (aw_idx)
                    `SPS_IDX_MOTOR_CTRL: begin
                        if (w_strb[0]) begin
                            mode <= w_data[2:0];
                            compare_clear_enable <= w_data[`SPS_CTRL_CLEAR_EN_BIT];
                        end
                    end
                    `SPS_IDX_STEP_COMPARE_VALUE: begin
                        if (w_strb[0]) begin
                            step_compare_value[7:0] <= w_data[7:0];
                        end
                        if (w_strb[1]) begin
                            step_compare_value[15:8] <= w_data[15:8];
                        end
                    end
                    `SPS_IDX_PHASE_OUT_DATA: begin
                        if (w_strb[0]) begin
                            phase_out_data <= w_data[7:0];
                        end
                    end
                    `SPS_IDX_INDEX_STATUS: begin
                        if (w_strb[0]) begin
                            phase_idx <= w_data[2:0];
                        end
                        if (w_strb[1]) begin
                            ramp_idx <= (w_data[13:8] > `SPS_RAMP_LAST) ?
                                `SPS_RAMP_LAST : w_data[13:8];
                        end
                    end
                    default: begin
                        ramp_idx <= ramp_idx;
                    end
                endcase
            end
        end
    end

    // Interrupt status, mask and the level output
    always @(posedge mclk) begin
        if (srst) begin
            interval_mode_ctrl <= `SPS_RST_INTERVAL_MODE;
            irq_status <= 3'h0;
            irq_mask <= 3'h0;
            irq <= 1'b0;
            phase_output_bits <= `SPS_RST_PINS;
        end else begin
            if (wr_low && aw_idx == `SPS_IDX_IRQ_STATUS) begin
                irq_status <= (irq_status & ~w_data[2:0]) | irq_events;
            end else begin
                irq_status <= irq_status | irq_events;
            end
            if (wr_low && aw_idx == `SPS_IDX_IRQ_MASK) begin
                irq_mask <= w_data[2:0];
            end
            if (wr_low && aw_idx == `SPS_IDX_INTERVAL_MODE_CTRL) begin
                interval_mode_ctrl <= w_data[7:0];
            end
            irq <= |(irq_status & irq_mask);
            phase_output_bits <= phase_out_data[3:0];
        end
    end

    // AXI write: address and data taken in either order, response after both
    always @(posedge mclk) begin
        if (srst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'b00;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 16'h0000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
        end else begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_idx <= reg_index(s_axi_awaddr);
                aw_held <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                w_held <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= mapped(aw_idx) ? 2'b00 : 2'b10;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI read: one cycle of address acceptance, data on the next edge
    always @(posedge mclk) begin
        if (srst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= mapped(reg_index(s_axi_araddr)) ? 2'b00 : 2'b10;
                case (reg_index(s_axi_araddr))
                    `SPS_IDX_INTERVAL_MODE_CTRL: s_axi_rdata <= {24'h0, interval_mode_ctrl};
                    `SPS_IDX_INTERVAL_COUNT: s_axi_rdata <= {24'h0, interval_count};
                    `SPS_IDX_STEP_COMPARE_VALUE: s_axi_rdata <= {16'h0, step_compare_value};
                    `SPS_IDX_PHASE_OUT_DATA: s_axi_rdata <= {24'h0, phase_out_data};
                    `SPS_IDX_IRQ_REQUEST_FLAGS_ONE:
                        s_axi_rdata <= {28'h0, interval_irq_flag, 3'h0};
                    `SPS_IDX_MOTOR_CTRL:
                        s_axi_rdata <= {28'h0, compare_clear_enable, mode};
                    `SPS_IDX_IRQ_STATUS: s_axi_rdata <= {29'h0, irq_status};
                    `SPS_IDX_IRQ_MASK: s_axi_rdata <= {29'h0, irq_mask};
                    `SPS_IDX_STEP_TIMER_COUNT: s_axi_rdata <= {16'h0, step_timer_count};
                    `SPS_IDX_INDEX_STATUS:
                        s_axi_rdata <= {15'h0, gap_busy, 2'h0, ramp_idx, 5'h0, phase_idx};
                    default: s_axi_rdata <= 32'h00000000;
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// ==== testbench/sps_monitor.sv ====
/* Port checker for the stepper phase sequencer: AXI answers, reset state, phase gap.
   Assumes one clock mclk and srst synchronous active high; bound to the top module. */
`timescale 1ns/1ps
module sps_monitor (
    input wire mclk,
    input wire srst,
    input wire s_axi_awready,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    input wire [31:0] s_axi_rdata,
    input wire [3:0] phase_output_bits,
    input wire irq
);
    reg [13:0] zero_cnt;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    // Length of the current run of dark phase outputs
    always @(posedge mclk) begin
        zero_cnt <= (srst || phase_output_bits != 4'h0) ? 14'h0 : zero_cnt + 14'h1;
    end
    a_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
        else $error("awready longer than one cycle");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_r_after_ar: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_reset_state: assert property (disable iff (1'b0) srst |=> phase_output_bits == 4'h8
        && !irq && !s_axi_bvalid && !s_axi_rvalid) else $error("bad reset state");
    a_gap_before: assert property ($changed(phase_output_bits) && phase_output_bits != 4'h0
        |-> $past(phase_output_bits) == 4'h0) else $error("pattern change without gap");
    a_gap_length: assert property (phase_output_bits != 4'h0 && $past(phase_output_bits)
        == 4'h0 |-> zero_cnt >= 14'h1F40 && zero_cnt <= 14'h206C) else $error("gap length");
    a_phase_legal: assert property (phase_output_bits inside {4'h0, 4'h8, 4'hC, 4'h4,
        4'h6, 4'h2, 4'h3, 4'h1, 4'h9}) else $error("illegal phase pattern");
endmodule
bind sps_stepper_phase_sequencer sps_monitor sps_monitor_inst (.mclk(mclk), .srst(srst),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .phase_output_bits(phase_output_bits), .irq(irq));

// ==== testbench/sps_phase_driver_model.sv ====
/* Behavioural two-phase driver stage on the four phase outputs.
   Assumes active-high phase bits: bit 3 A, bit 2 B, bit 1 A-bar, bit 0 B-bar. */
`timescale 1ns/1ps
module sps_phase_driver_model (
    input wire mclk,
    input wire srst,
    input wire [3:0] phase_output_bits,
    output reg [7:0] fault_count,
    output reg [7:0] gap_count
);
    reg [3:0] last_pattern;
    // A winding driven both ways at once would short its bridge, so count it
    always @(posedge mclk) begin
        if (srst) begin
            fault_count <= 8'h00;
            gap_count <= 8'h00;
            last_pattern <= 4'h8;
        end else begin
            if ((phase_output_bits[3] && phase_output_bits[1]) ||
                (phase_output_bits[2] && phase_output_bits[0])) fault_count <= fault_count + 8'h01;
            if (phase_output_bits != 4'h0 && last_pattern == 4'h0) gap_count <= gap_count + 8'h01;
            last_pattern <= phase_output_bits;
        end
    end
endmodule

// ==== testbench/sps_stepper_phase_sequencer_tb.sv ====
/* Self-checking bench: register map, interval timer, step modes, interrupt, phase pins.
   Assumes the designer's AXI4-Lite timing and a 25 MHz clock. */
`timescale 1ns/1ps
`include "sps_regs.vh"
module sps_stepper_phase_sequencer_tb;
    reg mclk = 1'b0;
    reg srst = 1'b1;
    reg [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    reg s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] phase_output_bits;
    wire [7:0] fault_count, gap_count;
    integer failures = 0, num_checks = 0, n, k;
    reg [31:0] rd;
    reg [1:0] rsp;
    reg [2:0] exp_idx;
    reg [5:0] ridx;
    sps_stepper_phase_sequencer sps_stepper_phase_sequencer_inst (.mclk(mclk), .srst(srst),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .phase_output_bits(phase_output_bits), .irq(irq));
    sps_phase_driver_model sps_phase_driver_model_inst (.mclk(mclk), .srst(srst),
        .phase_output_bits(phase_output_bits), .fault_count(fault_count), .gap_count(gap_count));
    // 25 MHz clock
    always #20 mclk = ~mclk;
    function [15:0] ramp(input [5:0] i);
        ramp = `SPS_RAMP_BASE - i * `SPS_RAMP_DELTA;
    endfunction
    function [3:0] pattern(input [2:0] i);
        case (i)
            3'h0: pattern = 4'h8;
            3'h1: pattern = 4'hC;
            3'h2: pattern = 4'h4;
            3'h3: pattern = 4'h6;
            3'h4: pattern = 4'h2;
            3'h5: pattern = 4'h3;
            3'h6: pattern = 4'h1;
            default: pattern = 4'h9;
        endcase
    endfunction
    task complete_run;
        begin
            if (failures == 0 && num_checks > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    task check32(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                failures = failures + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    // Waits a clock first so no handshake signal is driven twice in one step
    task axi_write(input [15:0] idx, input [31:0] d);
        begin
            @(posedge mclk);
            s_axi_awaddr <= {14'h0, idx, 2'h0};
            s_axi_wdata <= d;
            s_axi_awvalid <= 1'b1;
            s_axi_wvalid <= 1'b1;
            s_axi_bready <= 1'b1;
            do begin
                @(posedge mclk);
                if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
                if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            end while (s_axi_bvalid !== 1'b1);
            rsp = s_axi_bresp;
            s_axi_bready <= 1'b0;
        end
    endtask
    task axi_read(input [15:0] idx);
        begin
            @(posedge mclk);
            s_axi_araddr <= {14'h0, idx, 2'h0};
            s_axi_arvalid <= 1'b1;
            s_axi_rready <= 1'b1;
            do begin
                @(posedge mclk);
                if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            end while (s_axi_rvalid !== 1'b1);
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            s_axi_rready <= 1'b0;
        end
    endtask
    task read_check(input [15:0] idx, input [31:0] mask, input [31:0] exp);
        begin
            axi_read(idx);
            check32(rd & mask, exp);
        end
    endtask
    // One step in the given mode, then back to stop before the next match can fire
    task run_step(input [2:0] mode, input [5:0] wr_ridx, input [2:0] exp_mode,
                  input [15:0] exp_cmp, input [5:0] exp_ridx);
        begin
            axi_write(`SPS_IDX_INDEX_STATUS, {18'h0, wr_ridx, 5'h0, exp_idx});
            axi_write(`SPS_IDX_STEP_COMPARE_VALUE, 32'h20);
            // Align to a stop-mode match so none falls between mode write and clear
            axi_write(`SPS_IDX_IRQ_STATUS, 32'h7);
            repeat (2) @(posedge mclk);
            for (n = 0; n < 2000 && irq !== 1'b1; n = n + 1) @(posedge mclk);
            axi_write(`SPS_IDX_MOTOR_CTRL, {28'h0, 1'b1, mode});
            axi_write(`SPS_IDX_IRQ_STATUS, 32'h7);
            // irq lags the clear by a cycle
            repeat (2) @(posedge mclk);
            for (n = 0; n < 2000 && irq !== 1'b1; n = n + 1) @(posedge mclk);
            exp_idx = mode[2] ? exp_idx - 3'h1 : exp_idx + 3'h1;
            check32({31'h0, irq}, 32'h1);
            check32({28'h0, phase_output_bits}, 32'h0);
            read_check(`SPS_IDX_IRQ_REQUEST_FLAGS_ONE, 32'h8, 32'h0);
            read_check(`SPS_IDX_MOTOR_CTRL, 32'h7, {29'h0, exp_mode});
            read_check(`SPS_IDX_STEP_COMPARE_VALUE, 32'hFFFF, {16'h0, exp_cmp});
            read_check(`SPS_IDX_INDEX_STATUS, 32'h3F07, {18'h0, exp_ridx, 5'h0, exp_idx});
            axi_write(`SPS_IDX_STEP_COMPARE_VALUE, 32'h20);
            axi_write(`SPS_IDX_MOTOR_CTRL, 32'hB);
            axi_write(`SPS_IDX_IRQ_MASK, 32'h0);
            repeat (3) @(posedge mclk);
            check32({31'h0, irq}, 32'h0);
            axi_write(`SPS_IDX_IRQ_MASK, 32'h1);
            repeat (3) @(posedge mclk);
            check32({31'h0, irq}, 32'h1);
            axi_write(`SPS_IDX_IRQ_STATUS, 32'h1);
            repeat (3) @(posedge mclk);
            check32({31'h0, irq}, 32'h0);
            for (n = 0; n < 9000 && phase_output_bits === 4'h0; n = n + 1) @(posedge mclk);
            check32({28'h0, phase_output_bits}, {28'h0, pattern(exp_idx)});
            read_check(`SPS_IDX_IRQ_REQUEST_FLAGS_ONE, 32'h8, 32'h8);
        end
    endtask
    // Hang guard: the sequence needs about 57000 cycles
    initial begin
        repeat (90000) @(posedge mclk);
        failures = failures + 1;
        complete_run;
    end
    // Main sequence
    initial begin
        rd = $urandom(32'hECCD);
        repeat (12) @(posedge mclk);
        srst <= 1'b0;
        check32({28'h0, phase_output_bits}, 32'h8);
        read_check(`SPS_IDX_STEP_COMPARE_VALUE, 32'hFFFF, 32'h2710);
        axi_write(`SPS_IDX_STEP_COMPARE_VALUE, 32'h20);
        read_check(`SPS_IDX_INTERVAL_MODE_CTRL, 32'hFF, 32'h0);
        read_check(`SPS_IDX_PHASE_OUT_DATA, 32'hFF, 32'h8);
        read_check(`SPS_IDX_MOTOR_CTRL, 32'hF, 32'hB);
        read_check(`SPS_IDX_IRQ_MASK, 32'h7, 32'h0);
        axi_read(16'h0001);
        check32({rsp, rd[29:0]}, 32'h80000000);
        axi_write(16'h0001, 32'h5);
        check32({30'h0, rsp}, 32'h2);
        axi_write(`SPS_IDX_IRQ_MASK, 32'h1);
        for (k = 0; k < 4; k = k + 1) begin
            axi_write(`SPS_IDX_INTERVAL_MODE_CTRL, {28'h0, `SPS_CSEL_INTERVAL});
            repeat (320) @(posedge mclk);
            axi_read(`SPS_IDX_INTERVAL_COUNT);
            check32({31'h0, rd >= 32'h9 && rd <= 32'hB}, 32'h1);
            axi_write(`SPS_IDX_INTERVAL_MODE_CTRL, 32'hC + k);
            read_check(`SPS_IDX_INTERVAL_COUNT, 32'hFF, 32'h0);
        end
        axi_write(`SPS_IDX_INTERVAL_MODE_CTRL, {28'h0, `SPS_CSEL_INTERVAL});
        exp_idx = $urandom;
        ridx = 6'h2 + $urandom % 46;
        run_step(3'h1, 6'h0, 3'h1, 16'h20, 6'h0);
        run_step(3'h5, 6'h0, 3'h5, 16'h20, 6'h0);
        run_step(3'h0, 6'h3C, 3'h1, ramp(6'h2F), 6'h2F);
        run_step(3'h4, 6'h2F, 3'h5, ramp(6'h2F), 6'h2F);
        run_step(3'h2, ridx, 3'h2, ramp(ridx), ridx - 6'h1);
        run_step(3'h6, ridx, 3'h6, ramp(ridx), ridx - 6'h1);
        repeat (2000) @(posedge mclk);
        check32({28'h0, phase_output_bits}, {28'h0, pattern(exp_idx)});
        read_check(`SPS_IDX_INDEX_STATUS, 32'h7, {29'h0, exp_idx});
        check32({24'h0, fault_count}, 32'h0);
        check32({24'h0, gap_count}, 32'h6);
        complete_run;
    end
endmodule
